// ==== spp_port.sv ====
// Purpose : Serial peripheral port, master or slave, with flag pins and boot drive.
// Assumes : Control words are changed only while the port is idle.
// Notes   : Slave logic runs on the incoming serial clock; received words cross by toggle.
//
// Overview of operation
// - The master drives the serial clock; several selectable bit rates exist.
// - Master makes one clock cycle per bit, only while a word moves.
// - Data launches on one clock edge and is sampled on the opposite one.
// - Software sets clock polarity and phase, which define the transfer format.
// - A slave ignores clock activity while its select input is high.
// - The select input is active low; an outside master pulls it low.
// - A low select input while master is flagged as a multimaster error.
// - As master, any flag pin may serve as a slave-select output.
// - Flag pins are inputs or outputs by control bits, three-stated at reset.
// - In serial boot mode flag pin zero selects the boot memory.
// - In serial boot mode clock and master-out pins drive during reset, clock high.
// - Master sends on MOSI, receives on MISO; slave the other way round.
// - The output-disable bit turns off the slave data driver.
// - The open-drain bit makes the slave data output open-drain.
`timescale 1ns/100ps
module spp_port (
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic                  linkClk,
    input  wire logic                  bootMasterMode,
    input  wire spp_pkg::spp_ctrl_t    ctrl,
    input  wire spp_pkg::spp_flag_cfg_t flagCfg,
    input  wire logic                  slaveSelectN,
    input  wire logic                  mosiIn,
    input  wire logic                  misoIn,
    input  wire logic [3:0]            flagIn,
    input  wire logic                  txValid,
    input  wire logic [7:0]            txWord,
    input  wire logic                  rxReady,
    input  wire logic                  faultClr,
    output logic                       txReady,
    output logic                       rxValid,
    output logic [7:0]                 rxWord,
    output logic                       busy,
    output logic                       modeFault,
    output logic                       overrun,
    output logic                       sclkOut,
    output logic                       sclkOe,
    output logic                       mosiOut,
    output logic                       mosiOe,
    output logic                       misoOut,
    output logic                       misoOe,
    output logic [3:0]                 flagOut,
    output logic [3:0]                 flagOe,
    output logic [3:0]                 flagLevel
);

    spp_pkg::spp_sys_st_t q, d;
    spp_pkg::spp_pin_st_t pq, pd;
    spp_pkg::spp_slv_st_t sq, sd;
    logic [7:0] slvWordQ;
    logic       slvTogQ;
    logic       sampleClk;
    logic       slvRstN;
    logic       masterOn;
    logic [2:0] launchIdxQ;  // Kept apart from sq: it runs on the opposite edge

    // Half period of the serial clock in core cycles
    function automatic logic [7:0] halfCycles(input logic [1:0] sel);
        halfCycles = spp_pkg::BAUD_HALF_BASE << sel;
    endfunction : halfCycles

    // True when the given edge index is a sampling edge for this phase
    function automatic logic isSampleEdge(input logic [4:0] e, input logic cpha);
        isSampleEdge = (e[0] == cpha);
    endfunction : isSampleEdge

    assign masterOn  = ctrl.master && !q.modeFault && q.rstS2;
    assign txReady   = q.rstS2 && (q.state == spp_pkg::ST_IDLE) && !q.modeFault
                       && (ctrl.master ? (q.count != spp_pkg::BUF_FULL) : 1'b1);
    assign rxValid   = (q.count != 2'h0);
    assign rxWord    = q.mem[q.rdPtr];
    assign busy      = (q.state == spp_pkg::ST_SHIFT);
    assign modeFault = q.modeFault;
    assign overrun   = q.overrun;
    assign flagOut   = q.flagOut;
    assign flagOe    = q.flagOe;
    assign flagLevel = q.flagLevel;
    assign sclkOut   = pq.sclkOut;
    assign sclkOe    = pq.sclkOe;
    assign mosiOut   = pq.mosiOut;
    assign mosiOe    = pq.mosiOe;

    // Core-domain next state
    always_comb begin
        logic       push;
        logic [7:0] pushWord;
        logic       pop;
        logic [7:0] capWord;
        d        = q;
        push     = 1'b0;
        pushWord = '0;
        capWord  = '0;
        pop      = rxReady && (q.count != 2'h0);
        // Reset release is stretched so pins see a clean hand-over
        d.rstS1  = 1'b1;
        d.rstS2  = q.rstS1;
        if (q.rstS1 && !q.rstS2) begin
            d.bootLatched = pq.bootS2;
        end
        // Pin synchronisers
        d.misoS1 = misoIn;
        d.misoS2 = q.misoS1;
        d.ssS1   = slaveSelectN;
        d.ssS2   = q.ssS1;
        d.flagS1 = flagIn;
        d.flagS2 = q.flagS1;
        d.flagLevel = q.flagS2;
        d.togS1  = slvTogQ;
        d.togS2  = q.togS1;
        d.togS3  = q.togS2;
        // Another master pulling our select low; set beats clear
        if (faultClr) begin
            d.modeFault = 1'b0;
        end
        if (ctrl.master && !q.ssS2 && q.rstS2) begin
            d.modeFault = 1'b1;
        end
        // Slave word to transmit is loaded whenever offered in slave mode, selected or not
        if (!ctrl.master && txValid && txReady) begin
            d.slvTx = txWord;
        end
        // Received slave word arrives as a toggle edge; data is stable by then
        if (!ctrl.master && (q.togS2 != q.togS3)) begin
            push     = 1'b1;
            pushWord = slvWordQ;
        end
        // Master shift engine
        case (q.state)
            spp_pkg::ST_IDLE: begin
                d.sclk = ctrl.cpol;
                if (ctrl.master && txValid && txReady) begin
                    d.state   = spp_pkg::ST_SHIFT;
                    d.halfCnt = 8'h00;
                    d.edgeCnt = 5'h00;
                    // Phase 0 puts the first bit out before the first edge
                    if (!ctrl.cpha) begin
                        d.mosi    = txWord[7];
                        d.txShift = {txWord[6:0], 1'b0};
                    end else begin
                        d.txShift = txWord;
                    end
                end
            end
            spp_pkg::ST_SHIFT: begin
                if (q.modeFault || !ctrl.master) begin
                    d.state = spp_pkg::ST_IDLE;
                    d.sclk  = ctrl.cpol;
                end else if (q.halfCnt == halfCycles(ctrl.baudSel) - 8'h01) begin
                    d.halfCnt = 8'h00;
                    d.sclk    = ~q.sclk;
                    if (isSampleEdge(q.edgeCnt, ctrl.cpha)) begin
                        capWord   = {q.rxShift[6:0], q.misoS2};
                        d.rxShift = capWord;
                    end else begin
                        capWord = q.rxShift;
                        if (q.edgeCnt != spp_pkg::LAST_EDGE) begin
                            d.mosi    = q.txShift[7];
                            d.txShift = {q.txShift[6:0], 1'b0};
                        end
                    end
                    if (q.edgeCnt == spp_pkg::LAST_EDGE) begin
                        d.state  = spp_pkg::ST_IDLE;
                        push     = 1'b1;
                        pushWord = capWord;
                    end else begin
                        d.edgeCnt = q.edgeCnt + 5'h01;
                    end
                end else begin
                    d.halfCnt = q.halfCnt + 8'h01;
                end
            end
            default: begin
                d.state = spp_pkg::ST_IDLE;
            end
        endcase
        // Two-entry receive buffer; a slave word with no room is counted lost
        if (push && (q.count == spp_pkg::BUF_FULL) && !pop) begin
            d.overrun = 1'b1;
            push      = 1'b0;
        end
        if (push) begin
            d.mem[q.wrPtr] = pushWord;
            d.wrPtr        = ~q.wrPtr;
        end
        if (pop) begin
            d.rdPtr = ~q.rdPtr;
        end
        d.count = q.count + {1'b0, push} - {1'b0, pop};
        // Flag pins: select outputs in master mode if set in asSelect (pin zero also after boot), else plain I/O
        for (int i = 0; i < 4; i++) begin
            if (!q.rstS2) begin
                d.flagOe[i]  = 1'b0;
                d.flagOut[i] = 1'b0;
            end else if (ctrl.master && (flagCfg.asSelect[i] || (i == 0 && q.bootLatched))) begin
                d.flagOe[i]  = 1'b1;
                d.flagOut[i] = (d.state != spp_pkg::ST_SHIFT);
            end else begin
                d.flagOe[i]  = flagCfg.dir[i];
                d.flagOut[i] = flagCfg.value[i];
            end
        end
    end

    // Core-domain registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= spp_pkg::SYS_RST;
        end else begin
            q <= d;
        end
    end

    // Clock and master-out drivers; these run without reset so the boot
    // strap can steer them while reset is held
    always_comb begin
        pd        = pq;
        pd.bootS1 = bootMasterMode;
        pd.bootS2 = pq.bootS1;
        if (!q.rstS2) begin
            pd.sclkOe  = pq.bootS2;
            pd.sclkOut = spp_pkg::BOOT_CLK_LEVEL;
            pd.mosiOe  = pq.bootS2;
            pd.mosiOut = spp_pkg::BOOT_MOSI_LEVEL;
        end else begin
            pd.sclkOe  = masterOn;
            pd.sclkOut = q.sclk;
            pd.mosiOe  = masterOn;
            pd.mosiOut = q.mosi;
        end
    end

    always_ff @(posedge sys_clk) begin
        pq <= pd;
    end

    // Slave side: polarity and phase fold into one sampling clock so that
    // sampling is always its rising edge and launching its falling edge
    assign sampleClk = linkClk ^ (ctrl.cpol ^ ctrl.cpha);
    assign slvRstN   = arst_n && !slaveSelectN && !ctrl.master;

    always_comb begin
        sd = sq;
        sd.shift = {sq.shift[5:0], mosiIn};
        sd.idx   = sq.idx + 3'h1;
        sd.launchIdx = launchIdxQ;
    end

    // Bit counter and shifter, cleared whenever the select goes high
    always_ff @(posedge sampleClk or negedge slvRstN) begin
        if (!slvRstN) begin
            sq <= spp_pkg::SLV_RST;
        end else begin
            sq <= sd;
        end
    end

    // Launch pointer moves on the edge opposite to sampling
    always_ff @(negedge sampleClk or negedge slvRstN) begin
        if (!slvRstN) begin
            launchIdxQ <= spp_pkg::SLV_RST.launchIdx;
        end else begin
            launchIdxQ <= sq.idx;
        end
    end

    // Completed word and its toggle survive deselection, so no false edge
    always_ff @(posedge sampleClk or negedge arst_n) begin
        if (!arst_n) begin
            slvWordQ <= 8'h00;
            slvTogQ  <= 1'b0;
        end else if (slvRstN && sq.idx == spp_pkg::LAST_BIT) begin
            slvWordQ <= {sq.shift, mosiIn};
            slvTogQ  <= ~slvTogQ;
        end
    end

    // Slave data driver; open-drain only pulls low
    assign misoOut = ctrl.open_drain_select ? 1'b0 : q.slvTx[3'(spp_pkg::LAST_BIT - launchIdxQ)];
    assign misoOe  = !ctrl.master && !slaveSelectN && !ctrl.slave_output_disable
                     && (!ctrl.open_drain_select || !q.slvTx[3'(spp_pkg::LAST_BIT - launchIdxQ)]);

    // Helper: serial clock toggles seen in the current word
    logic [4:0] tglCnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tglCnt <= 5'h00;
        end else if (q.state == spp_pkg::ST_IDLE) begin
            tglCnt <= 5'h00;
        end else if (d.sclk != q.sclk) begin
            tglCnt <= tglCnt + 5'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence wordAccept;
        ctrl.master && txValid && txReady && q.ssS2;
    endsequence

    sequence firstEdge;
        busy ##[1:70] (q.sclk != $past(q.sclk));
    endsequence

    AST_IDLE_LEVEL: assert property ((q.state == spp_pkg::ST_IDLE) && $past(q.state == spp_pkg::ST_IDLE)
        && $stable(ctrl.cpol) |-> q.sclk == ctrl.cpol)
        else $error("serial clock not at idle level between words");
    AST_EDGE_COUNT: assert property (busy ##1 (!busy && !q.modeFault) |->
        tglCnt == 5'(spp_pkg::EDGES_PER_WORD) &&
        $past(tglCnt) == 5'(spp_pkg::EDGES_PER_WORD - 1))
        else $error("word did not carry exactly one clock cycle per bit");
    AST_START: assert property (wordAccept |-> ##1 firstEdge)
        else $error("accepted word did not start clocking");
    AST_FAULT_SET: assert property (ctrl.master && !q.ssS2 && q.rstS2 |=> q.modeFault)
        else $error("low select while master not flagged");
    AST_FAULT_DROP: assert property (q.modeFault && q.rstS2 |=> !sclkOe && !mosiOe)
        else $error("master drivers stayed on after fault");
    AST_FLAG_RESET: assert property (!q.rstS2 |-> flagOe == 4'h0)
        else $error("flag pins driven during reset");
    AST_BOOT_DRIVE: assert property (!q.rstS2 && !$past(q.rstS2) && pq.bootS2 |=>
        (!q.rstS2 |-> sclkOe && sclkOut && mosiOe))
        else $error("boot mode pins not driven in reset");
    AST_MISO_OFF: assert property (ctrl.slave_output_disable || ctrl.master |-> !misoOe)
        else $error("slave data driver on while disabled or master");
    AST_OPEN_DRAIN: assert property (ctrl.open_drain_select && misoOe |-> !misoOut)
        else $error("open-drain output drove high");
    AST_LAUNCH_EDGE: assert property (busy && (q.mosi != $past(q.mosi)) && $past(busy)
        |-> (q.sclk != $past(q.sclk)) && ($past(q.edgeCnt[0]) != ctrl.cpha))
        else $error("data changed away from launch edge");

endmodule : spp_port

// ==== spp_pkg.sv ====
// Purpose : Shared constants and carrier types for the serial peripheral port.
// Assumes : Word length and buffer depth are fixed; core clock is 50 MHz.
// Notes   : Every field position, the word and bit-rate counts, and the state-record reset values, live here.
package spp_pkg;

    // Word format
    localparam int WORD_W         = 8;
    localparam int EDGES_PER_WORD = 2 * WORD_W;
    localparam logic [4:0] LAST_EDGE = 5'(EDGES_PER_WORD - 1);
    localparam logic [2:0] LAST_BIT  = 3'(WORD_W - 1);

    // Bit-rate divider: half period in core cycles is BASE shifted by baudSel
    localparam logic [7:0] BAUD_HALF_BASE = 8'h04;

    // Receive buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'(BUF_DEPTH);

    // Pin levels driven while the boot straps hold the port in reset
    localparam logic BOOT_CLK_LEVEL  = 1'b1;
    localparam logic BOOT_MOSI_LEVEL = 1'b0;

    // Software-visible control word (serial_port_control_reg)
    typedef struct packed {
        logic       master;     // 1 = master, 0 = slave
        logic       cpol;       // Idle level of the serial clock
        logic       cpha;       // 1 = sample on trailing edge
        logic       slave_output_disable;      // slave_output_disable
        logic       open_drain_select;        // open_drain_select
        logic [1:0] baudSel;    // Bit-rate select
    } spp_ctrl_t;

    // General flag pin configuration
    typedef struct packed {
        logic [3:0] dir;        // 1 = output
        logic [3:0] value;      // Level driven when output
        logic [3:0] asSelect;   // Use as slave-select output in master mode
    } spp_flag_cfg_t;

    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} spp_state_t;

    // Core-domain state
    typedef struct packed {
        logic                       rstS1;
        logic                       rstS2;
        logic                       bootLatched;
        spp_state_t                 state;
        logic [7:0]                 halfCnt;
        logic [4:0]                 edgeCnt;
        logic                       sclk;
        logic                       mosi;
        logic [WORD_W-1:0]          txShift;
        logic [WORD_W-1:0]          rxShift;
        logic [WORD_W-1:0]          slvTx;
        logic                       misoS1;
        logic                       misoS2;
        logic                       ssS1;
        logic                       ssS2;
        logic [3:0]                 flagS1;
        logic [3:0]                 flagS2;
        logic                       togS1;
        logic                       togS2;
        logic                       togS3;
        logic [BUF_DEPTH-1:0][WORD_W-1:0] mem;
        logic                       wrPtr;
        logic                       rdPtr;
        logic [1:0]                 count;
        logic                       modeFault;
        logic                       overrun;
        logic [3:0]                 flagOut;
        logic [3:0]                 flagOe;
        logic [3:0]                 flagLevel;
    } spp_sys_st_t;

    // Pin drivers that must also act while reset is applied
    typedef struct packed {
        logic bootS1;
        logic bootS2;
        logic sclkOut;
        logic sclkOe;
        logic mosiOut;
        logic mosiOe;
    } spp_pin_st_t;

    // Link-domain slave state
    typedef struct packed {
        logic [2:0]        idx;
        logic [WORD_W-2:0] shift;
        logic [2:0]        launchIdx;
    } spp_slv_st_t;

    localparam spp_sys_st_t SYS_RST = '0;
    localparam spp_slv_st_t SLV_RST = '0;

endpackage : spp_pkg

// ==== spp_slave_model.sv ====
// Purpose : Behavioural serial slave facing the port while it is master.
// Assumes : Select is active low; released data lines sit at the pull-up level.
// Notes   : Reloads its answer word at each select and after each full word.
`timescale 1ns/100ps
module spp_slave_model (
    input  wire logic       sclk,
    input  wire logic       selN,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] loadWord,
    output logic            miso,
    output logic [7:0]      gotWord
);
    logic [7:0] sh;
    logic [3:0] n;
    logic       hold;
    wire        smp = sclk ^ cpol ^ cpha;  // Rises on every sampling edge

    // Selection presents the first bit; trailing-edge phase waits for the first edge
    always @(negedge selN) begin
        sh = loadWord;
        n = 4'h0;
        hold = cpha;
    end

    // Sample incoming data on one edge only
    always @(posedge smp) if (!selN) begin
        gotWord = {gotWord[6:0], mosi};
        n = n + 4'h1;
    end

    // Launch on the opposite edge; a finished word reloads the answer
    always @(negedge smp) if (!selN) begin
        if (hold) begin
            hold = 1'b0;
        end else if (n == 4'h8) begin
            sh = loadWord;
            n = 4'h0;
        end else begin
            sh = {sh[6:0], 1'b0};
        end
    end

    // Unselected, the line floats up, so a stale bit never looks valid
    assign miso = selN ? 1'b1 : sh[7];
endmodule : spp_slave_model

// ==== spp_port_bench.sv ====
// Purpose : Self-checking bench for the serial peripheral port.
// Assumes : Clock 50 MHz; link clock 125 ns, made only inside slave frames.
// Notes   : Pins are resolved here with pull-ups; seed fixed for repeatable runs.
`timescale 1ns/100ps
module spp_port_bench;
    logic                   sys_clk, arst_n, bootMasterMode, slaveSelectN, txValid, rxReady;
    logic                   faultClr, linkDrv, mosiDrv, txReady, rxValid, busy, modeFault;
    logic                   overrun, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
    logic                   modelMiso, lastClk, sawSel, sel;
    logic [7:0]             txWord, rxWord, gotWord, slvWord, w, toggles, got;
    logic [7:0]             m [3];
    logic [3:0]             flagIn, flagOut, flagOe, flagLevel;
    spp_pkg::spp_ctrl_t     ctrl;
    spp_pkg::spp_flag_cfg_t flagCfg;
    int                     err_total, samples_checked, i;

    // Pin resolution: MISO and select lines have pull-ups; clock and MOSI fall back to linkDrv and mosiDrv
    wire sclkPin = sclkOe ? sclkOut : linkDrv;
    wire mosiPin = mosiOe ? mosiOut : mosiDrv;
    wire misoPin = misoOe ? misoOut : 1'b1;
    wire selPin  = flagOe[1] ? flagOut[1] : 1'b1;

    spp_port dut (.sys_clk(sys_clk), .arst_n(arst_n), .linkClk(sclkPin),
        .bootMasterMode(bootMasterMode), .ctrl(ctrl), .flagCfg(flagCfg),
        .slaveSelectN(slaveSelectN), .mosiIn(mosiPin), .misoIn(modelMiso), .flagIn(flagIn),
        .txValid(txValid), .txWord(txWord), .rxReady(rxReady), .faultClr(faultClr),
        .txReady(txReady), .rxValid(rxValid), .rxWord(rxWord), .busy(busy),
        .modeFault(modeFault), .overrun(overrun), .sclkOut(sclkOut), .sclkOe(sclkOe),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe),
        .flagOut(flagOut), .flagOe(flagOe), .flagLevel(flagLevel));

    spp_slave_model slave (.sclk(sclkPin), .selN(selPin), .mosi(mosiPin), .cpol(ctrl.cpol),
        .cpha(ctrl.cpha), .loadWord(slvWord), .miso(modelMiso), .gotWord(gotWord));

    // Core clock, 20 ns
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Count clock pin toggles and watch the flag select during a word
    always @(posedge sys_clk) begin
        if (sclkPin !== lastClk) toggles <= toggles + 8'h01;
        lastClk <= sclkPin;
        if (busy === 1'b1 && flagOe[2] === 1'b1 && flagOut[2] === 1'b0) sawSel <= 1'b1;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Bounded wait at falling edges until a signal reaches a level
    task automatic await(input string name, ref logic sig, input logic lvl);
        int k;
        for (k = 0; k < 3000 && sig !== lvl; k++) @(negedge sys_clk);
        if (sig !== lvl) begin
            chk(name, 8'h00, 8'hEE);
            tally_and_finish();
        end
    endtask : await

    // Request held until taken at a rising edge
    task automatic push(input logic [7:0] d);
        @(negedge sys_clk);
        txValid = 1'b1;
        txWord = d;
        await("tx_ready", txReady, 1'b1);
        @(negedge sys_clk);
        txValid = 1'b0;
    endtask : push

    task automatic pop(input logic [7:0] exp);
        await("rx_valid", rxValid, 1'b1);
        chk("rx_word", exp, rxWord);
        rxReady = 1'b1;
        @(negedge sys_clk);
        rxReady = 1'b0;
    endtask : pop

    // Bench as outside master, mode 0: launch on falling, sample on rising
    task automatic frame(input logic [7:0] mw, input logic s, output logic [7:0] rd);
        int b;
        #7 slaveSelectN = ~s;
        #125;
        for (b = 7; b >= 0; b--) begin
            mosiDrv = mw[b];
            #62.5 rd[b] = misoPin;
            linkDrv = 1'b1;
            #62.5 linkDrv = 1'b0;
        end
        #125 slaveSelectN = 1'b1;
        mosiDrv = 1'b1;
    endtask : frame

    initial begin
        {arst_n, bootMasterMode, txValid, rxReady, faultClr, linkDrv, toggles} = '0;
        {slaveSelectN, mosiDrv, lastClk, sawSel} = 4'hF;
        {txWord, slvWord, flagIn, ctrl} = '0;
        flagCfg = '{dir: 4'b0110, value: 4'b0010, asSelect: 4'b0100};
        err_total = 0;
        samples_checked = 0;
        void'($urandom(19));
        repeat (8) @(negedge sys_clk);
        chk("reset_flag_oe", 8'h00, {4'h0, flagOe});
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        // Every clock format, random rates and data
        for (i = 0; i < 8; i++) begin
            ctrl = '{master: 1'b1, cpol: i[1], cpha: i[0], slave_output_disable: 1'b0, open_drain_select: 1'b0,
                     baudSel: 2'($urandom)};
            slvWord = 8'($urandom);
            w = 8'($urandom);
            flagIn = 4'($urandom);
            repeat (4) @(negedge sys_clk);
            chk("flag_level", {7'h0, flagIn[3]}, {7'h0, flagLevel[3]});
            flagCfg.value[1] = 1'b0;
            toggles = 8'h00;
            sawSel = 1'b0;
            push(w);
            await("busy", busy, 1'b0);
            repeat (3) @(negedge sys_clk);
            flagCfg.value[1] = 1'b1;
            chk("sclk_toggles", 8'h10, toggles);
            chk("sclk_idle", {7'h0, ctrl.cpol}, {7'h0, sclkPin});
            chk("slave_got", w, gotWord);
            chk("flag_select", 8'h01, {7'h0, sawSel});
            pop(slvWord);
        end
        // Low select while master
        slaveSelectN = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("fault_set", 8'h01, {7'h0, modeFault});
        chk("fault_ready", 8'h00, {7'h0, txReady});
        slaveSelectN = 1'b1;
        repeat (4) @(negedge sys_clk);
        faultClr = 1'b1;
        @(negedge sys_clk);
        faultClr = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("fault_clr", 8'h00, {7'h0, modeFault});
        // Slave frames: push-pull, open-drain, disabled, the last one lost
        ctrl = '0;
        flagCfg = '0;
        for (i = 0; i < 3; i++) begin
            ctrl.open_drain_select = (i == 1);
            ctrl.slave_output_disable = (i == 2);
            w = 8'($urandom);
            if (i < 2) push(w);
            m[i] = 8'($urandom);
            frame(m[i], 1'b1, got);
            chk("slave_out", (i == 2) ? 8'hFF : w, got);
        end
        repeat (20) @(negedge sys_clk);
        chk("overrun", 8'h01, {7'h0, overrun});
        pop(m[0]);
        pop(m[1]);
        frame(8'($urandom), 1'b0, got);
        repeat (20) @(negedge sys_clk);
        chk("unselected", 8'h00, {7'h0, rxValid});
        // Serial boot strap held through a second reset
        ctrl.master = 1'b1;
        bootMasterMode = 1'b1;
        arst_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("boot_drive", 8'h07, {5'h0, sclkOe, sclkOut, mosiOe});
        arst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk("boot_select", 8'h01, {7'h0, flagOe[0]});
        tally_and_finish();
    end
endmodule : spp_port_bench
